// ---- inc/sense_pkg.sv ----
// Shared constants and types of the light/proximity sequencer and its host
package sense_pkg;

  // ------------------------------------------------------------
  // Clocks and timing
  // ------------------------------------------------------------
  localparam longint CLK_HZ = 25_000_000;
  localparam longint OSC_REF_HZ = 725_000;
  localparam longint SCALE_REF_OHM = 499_000;
  localparam longint MOD_HZ = 360_000;
  localparam int MOD_HALF_CYC = int'(CLK_HZ / (2 * MOD_HZ));
  localparam longint INIT_WAIT_NS = 1_000_000;
  localparam int INIT_WAIT_CYC = int'((INIT_WAIT_NS * CLK_HZ + 999_999_999) / 1_000_000_000);

  // ------------------------------------------------------------
  // Sensor register map (link addresses)
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_CMD1 = 4'h0;
  localparam logic [3:0] ADDR_CMD2 = 4'h1;
  localparam logic [3:0] ADDR_DATA_LO = 4'h2;
  localparam logic [3:0] ADDR_DATA_HI = 4'h3;
  localparam logic [3:0] ADDR_TLO_LO = 4'h4;
  localparam logic [3:0] ADDR_TLO_HI = 4'h5;
  localparam logic [3:0] ADDR_THI_LO = 4'h6;
  localparam logic [3:0] ADDR_THI_HI = 4'h7;
  localparam logic [3:0] ADDR_TEST = 4'h8;

  // Command one fields
  localparam int C1_RUN = 7;
  localparam int C1_SRC_PROX = 5;
  localparam int C1_FLAG = 2;
  localparam int C1_PERS = 0;
  // Command two fields
  localparam int C2_SCHEME = 7;
  localparam int C2_MOD = 6;
  localparam int C2_CUR = 4;
  localparam int C2_RES = 2;

  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [15:0] TLO_RST = 16'h0000;
  localparam logic [15:0] THI_RST = 16'hffff;

  // Persistence and resolution encodings
  localparam logic [4:0] PERS_00 = 5'h01;
  localparam logic [4:0] PERS_01 = 5'h04;
  localparam logic [4:0] PERS_10 = 5'h08;
  localparam logic [4:0] PERS_11 = 5'h10;
  localparam logic [4:0] RES_00 = 5'h10;
  localparam logic [4:0] RES_01 = 5'h0c;
  localparam logic [4:0] RES_10 = 5'h08;
  localparam logic [4:0] RES_11 = 5'h04;

  // ------------------------------------------------------------
  // Host APB map
  // ------------------------------------------------------------
  localparam logic [11:0] APB_CMD = 12'h000;
  localparam logic [11:0] APB_STATUS = 12'h004;
  localparam logic [11:0] APB_IRQ_STAT = 12'h008;
  localparam logic [11:0] APB_IRQ_MASK = 12'h00c;
  localparam int CMD_GO = 0;
  localparam int CMD_INIT = 1;
  localparam int CMD_WE = 12;
  localparam int CMD_ADDR = 8;
  localparam int CMD_WDATA = 16;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_SENSOR = 1;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ALS = 2'b01,
    SEQ_IR = 2'b11,
    SEQ_PROX = 2'b10
  } seq_e;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_ACC = 3'b001,
    H_INI_TEST = 3'b011,
    H_INI_CMD = 3'b010,
    H_INI_WAIT = 3'b110
  } host_e;

endpackage : sense_pkg

// ---- inc/sense_link_if.sv ----
// Register link between the sensor sequencer and its host controller
interface sense_link_if;
  logic req;
  logic we;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  logic int_n;

  modport dev (input req, input we, input addr, input wdata,
               output ack, output rdata, output int_n);
  modport host (output req, output we, output addr, output wdata,
                input ack, input rdata, input int_n);
endinterface : sense_link_if

// ---- hdl/light_prox_sense_sequencer.sv ----
// Sensor end: registers, detection cycle sequencer, LED drive and interrupt
//
// Function
// - Conversion clock scales inversely with scaling_resistor
// - Flag when data leaves threshold window
// - Host reads command one; flag and pin clear
// - Host writes flag bit zero before use
// - Pin low after persistence count of misses
// - Host resets test, command one, waits, rewrites
// - LED DC or 360 kHz half duty
// - Current field selects four doubling levels
// - Ambient, IR, proximity phases run serially
// - LED driven only in proximity phase
// - Scheme one subtracts IR, signed result
// - Host may difference proximity and IR results
// - Persistence codes give 1, 4, 8, 16
// - Thresholds at 04..07, reset zeros/ones
// - Resolution gives 2^n oscillator cycles
//
// Decided for this implementation: the APB register port and the placing of the registers.
module light_prox_sense_sequencer #(
  parameter longint SCALE_OHM = 499_000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link to host
  sense_link_if.dev link,
  // Analog front-end results
  input wire logic [15:0] als_level,
  input wire logic [15:0] ir_level,
  input wire logic [15:0] prox_level,
  // LED driver and cycle phase
  output logic led_drive_pin,
  output logic [1:0] led_current_sel,
  output logic [1:0] phase
);

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam longint OSC_DIV_RAW = (sense_pkg::CLK_HZ * SCALE_OHM) /
                                   (sense_pkg::OSC_REF_HZ * sense_pkg::SCALE_REF_OHM);
  localparam int OSC_DIV = (OSC_DIV_RAW < 1) ? 1 : int'(OSC_DIV_RAW);

  typedef struct packed {
    logic [7:0] cmd1;
    logic [7:0] cmd2;
    logic [15:0] tlo;
    logic [15:0] thi;
    logic [7:0] test;
    logic [15:0] data;
    logic [15:0] ir_keep;
    sense_pkg::seq_e seq;
    logic [15:0] osc_cnt;
    logic [16:0] int_cnt;
    logic [4:0] pers;
    logic [15:0] mod_cnt;
    logic mod_ph;
    logic ack;
    logic [7:0] rdata;
    logic int_n;
    logic led;
    logic [1:0] led_sel;
  } dev_s;

  dev_s s_r;
  dev_s s_nxt;

  logic hit;
  logic tick;
  logic done;
  logic [4:0] res_n;
  logic [4:0] pers_m;
  logic [16:0] len;
  logic [15:0] mask;
  logic [15:0] sample;
  logic signed [16:0] diff;
  logic signed [16:0] lim;
  logic compare;
  logic outside;

  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    hit = link.req && !s_r.ack;
    tick = 1'b0;
    done = 1'b0;
    sample = 16'h0000;
    diff = 17'sh00000;
    compare = 1'b0;
    outside = 1'b0;

    // ------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------
    if (hit) begin
      s_nxt.ack = 1'b1;
      if (link.we) begin
        unique case (link.addr)
          sense_pkg::ADDR_CMD1: s_nxt.cmd1 = link.wdata;
          sense_pkg::ADDR_CMD2: s_nxt.cmd2 = link.wdata;
          sense_pkg::ADDR_TLO_LO: s_nxt.tlo[7:0] = link.wdata;
          sense_pkg::ADDR_TLO_HI: s_nxt.tlo[15:8] = link.wdata;
          sense_pkg::ADDR_THI_LO: s_nxt.thi[7:0] = link.wdata;
          sense_pkg::ADDR_THI_HI: s_nxt.thi[15:8] = link.wdata;
          sense_pkg::ADDR_TEST: s_nxt.test = link.wdata;
          default: ;
        endcase
      end else begin
        unique case (link.addr)
          sense_pkg::ADDR_CMD1: s_nxt.rdata = s_r.cmd1;
          sense_pkg::ADDR_CMD2: s_nxt.rdata = s_r.cmd2;
          sense_pkg::ADDR_DATA_LO: s_nxt.rdata = s_r.data[7:0];
          sense_pkg::ADDR_DATA_HI: s_nxt.rdata = s_r.data[15:8];
          sense_pkg::ADDR_TLO_LO: s_nxt.rdata = s_r.tlo[7:0];
          sense_pkg::ADDR_TLO_HI: s_nxt.rdata = s_r.tlo[15:8];
          sense_pkg::ADDR_THI_LO: s_nxt.rdata = s_r.thi[7:0];
          sense_pkg::ADDR_THI_HI: s_nxt.rdata = s_r.thi[15:8];
          sense_pkg::ADDR_TEST: s_nxt.rdata = s_r.test;
          default: s_nxt.rdata = 8'h00;
        endcase
        // Read of command one clears the pending flag
        if (link.addr == sense_pkg::ADDR_CMD1) begin
          s_nxt.cmd1[sense_pkg::C1_FLAG] = 1'b0;
        end
      end
    end

    // ------------------------------------------------------------
    // Conversion clock and field decode
    // ------------------------------------------------------------
    if (s_r.osc_cnt == 16'(OSC_DIV - 1)) begin
      s_nxt.osc_cnt = 16'h0000;
      tick = 1'b1;
    end else begin
      s_nxt.osc_cnt = s_r.osc_cnt + 16'h0001;
    end

    unique case (s_r.cmd2[sense_pkg::C2_RES +: 2])
      2'b00: res_n = sense_pkg::RES_00;
      2'b01: res_n = sense_pkg::RES_01;
      2'b10: res_n = sense_pkg::RES_10;
      2'b11: res_n = sense_pkg::RES_11;
    endcase
    unique case (s_r.cmd1[sense_pkg::C1_PERS +: 2])
      2'b00: pers_m = sense_pkg::PERS_00;
      2'b01: pers_m = sense_pkg::PERS_01;
      2'b10: pers_m = sense_pkg::PERS_10;
      2'b11: pers_m = sense_pkg::PERS_11;
    endcase
    len = 17'h00001 << res_n;
    mask = 16'(len - 17'h00001);
    lim = signed'(17'(len >> 1));

    // ------------------------------------------------------------
    // Detection cycle
    // ------------------------------------------------------------
    unique case (s_r.seq)
      sense_pkg::SEQ_IDLE: begin
        if (s_r.cmd1[sense_pkg::C1_RUN]) begin
          s_nxt.seq = sense_pkg::SEQ_ALS;
          s_nxt.int_cnt = 17'h00000;
          s_nxt.osc_cnt = 16'h0000;
        end
      end
      default: begin
        if (tick) begin
          s_nxt.int_cnt = s_r.int_cnt + 17'h00001;
          done = (s_r.int_cnt + 17'h00001) == len;
        end
      end
    endcase

    if (done) begin
      s_nxt.int_cnt = 17'h00000;
      unique case (s_r.seq)
        sense_pkg::SEQ_ALS: begin
          sample = als_level & mask;
          s_nxt.seq = sense_pkg::SEQ_IR;
          compare = !s_r.cmd1[sense_pkg::C1_SRC_PROX];
        end
        sense_pkg::SEQ_IR: begin
          sample = ir_level & mask;
          s_nxt.ir_keep = sample;
          s_nxt.seq = sense_pkg::SEQ_PROX;
        end
        default: begin
          sample = prox_level & mask;
          if (s_r.cmd2[sense_pkg::C2_SCHEME]) begin
            // Background IR removed on chip, clamped to n-1 magnitude bits
            diff = signed'({1'b0, sample}) - signed'({1'b0, s_r.ir_keep});
            if (diff > lim - 17'sh00001) begin
              diff = lim - 17'sh00001;
            end else if (diff < -lim) begin
              diff = -lim;
            end
            sample = diff[15:0];
          end
          compare = s_r.cmd1[sense_pkg::C1_SRC_PROX];
          s_nxt.seq = s_r.cmd1[sense_pkg::C1_RUN] ? sense_pkg::SEQ_ALS : sense_pkg::SEQ_IDLE;
        end
      endcase
      s_nxt.data = sample;
    end

    // ------------------------------------------------------------
    // Window compare and persistence
    // ------------------------------------------------------------
    if (compare) begin
      outside = (sample < s_r.tlo) || (sample > s_r.thi);
      if (!outside) begin
        s_nxt.pers = 5'h00;
      end else begin
        if (s_r.pers != sense_pkg::PERS_11) begin
          s_nxt.pers = s_r.pers + 5'h01;
        end
        // Set after the clear so an event in the read cycle is kept
        if (s_r.pers + 5'h01 >= pers_m) begin
          s_nxt.cmd1[sense_pkg::C1_FLAG] = 1'b1;
        end
      end
    end
    s_nxt.int_n = !s_nxt.cmd1[sense_pkg::C1_FLAG];

    // ------------------------------------------------------------
    // LED drive
    // ------------------------------------------------------------
    if (s_r.mod_cnt == 16'(sense_pkg::MOD_HALF_CYC - 1)) begin
      s_nxt.mod_cnt = 16'h0000;
      s_nxt.mod_ph = !s_r.mod_ph;
    end else begin
      s_nxt.mod_cnt = s_r.mod_cnt + 16'h0001;
    end
    // Phase restarts so each proximity burst begins with LED on
    if (s_nxt.seq != sense_pkg::SEQ_PROX) begin
      s_nxt.mod_cnt = 16'h0000;
      s_nxt.mod_ph = 1'b1;
    end
    s_nxt.led = (s_nxt.seq == sense_pkg::SEQ_PROX) &&
                (!s_nxt.cmd2[sense_pkg::C2_MOD] || s_nxt.mod_ph);
    s_nxt.led_sel = s_nxt.cmd2[sense_pkg::C2_CUR +: 2];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.cmd1 <= sense_pkg::CMD_RST;
      s_r.cmd2 <= sense_pkg::CMD_RST;
      s_r.tlo <= sense_pkg::TLO_RST;
      s_r.thi <= sense_pkg::THI_RST;
      s_r.seq <= sense_pkg::SEQ_IDLE;
      s_r.mod_ph <= 1'b1;
      s_r.int_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.ack = s_r.ack;
  assign link.rdata = s_r.rdata;
  assign link.int_n = s_r.int_n;
  assign led_drive_pin = s_r.led;
  assign led_current_sel = s_r.led_sel;
  assign phase = s_r.seq;

endmodule : light_prox_sense_sequencer

// ---- hdl/sense_host.sv ----
// Host end: APB registers driving link accesses and the power-up sequence
module sense_host #(
  parameter int INIT_WAIT_CYC = sense_pkg::INIT_WAIT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  // Interrupt
  output logic irq,
  // Link to sensor
  sense_link_if.host link
);

  typedef struct packed {
    sense_pkg::host_e st;
    logic req;
    logic we;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [31:0] wait_cnt;
    logic int_n_d;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic irq;
  } host_s;

  host_s s_r;
  host_s s_nxt;
  logic acc;
  logic ev_done;
  logic ev_int;

  always_comb begin
    s_nxt = s_r;
    s_nxt.pready = 1'b0;
    acc = psel && penable && !s_r.pready;
    ev_done = 1'b0;

    // ------------------------------------------------------------
    // Link sequencing
    // ------------------------------------------------------------
    unique case (s_r.st)
      sense_pkg::H_IDLE: ;
      sense_pkg::H_ACC: begin
        if (link.ack) begin
          s_nxt.req = 1'b0;
          s_nxt.rdata = link.rdata;
          s_nxt.st = sense_pkg::H_IDLE;
          ev_done = 1'b1;
        end
      end
      sense_pkg::H_INI_TEST: begin
        if (link.ack) begin
          s_nxt.addr = sense_pkg::ADDR_CMD1;
          s_nxt.st = sense_pkg::H_INI_CMD;
        end
      end
      sense_pkg::H_INI_CMD: begin
        if (link.ack) begin
          s_nxt.req = 1'b0;
          s_nxt.wait_cnt = 32'h00000000;
          s_nxt.st = sense_pkg::H_INI_WAIT;
        end
      end
      sense_pkg::H_INI_WAIT: begin
        s_nxt.wait_cnt = s_r.wait_cnt + 32'h00000001;
        if (s_r.wait_cnt == 32'(INIT_WAIT_CYC - 1)) begin
          s_nxt.st = sense_pkg::H_IDLE;
          ev_done = 1'b1;
        end
      end
      default: s_nxt.st = sense_pkg::H_IDLE;
    endcase

    // ------------------------------------------------------------
    // APB slave, one wait state
    // ------------------------------------------------------------
    if (acc) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = 32'h00000000;
      if (pwrite) begin
        unique case (paddr)
          sense_pkg::APB_CMD: begin
            // Ignored while busy so an access in flight is never altered
            if (s_r.st == sense_pkg::H_IDLE) begin
              if (pwdata[sense_pkg::CMD_INIT]) begin
                s_nxt.req = 1'b1;
                s_nxt.we = 1'b1;
                s_nxt.addr = sense_pkg::ADDR_TEST;
                s_nxt.wdata = 8'h00;
                s_nxt.st = sense_pkg::H_INI_TEST;
              end else if (pwdata[sense_pkg::CMD_GO]) begin
                s_nxt.req = 1'b1;
                s_nxt.we = pwdata[sense_pkg::CMD_WE];
                s_nxt.addr = pwdata[sense_pkg::CMD_ADDR +: 4];
                s_nxt.wdata = pwdata[sense_pkg::CMD_WDATA +: 8];
                s_nxt.st = sense_pkg::H_ACC;
              end
            end
          end
          sense_pkg::APB_IRQ_STAT: s_nxt.stat = s_r.stat & ~pwdata[1:0];
          sense_pkg::APB_IRQ_MASK: s_nxt.mask = pwdata[1:0];
          default: ;
        endcase
      end else begin
        unique case (paddr)
          sense_pkg::APB_STATUS:
            s_nxt.prdata = {16'h0000, s_r.rdata, 6'h00, !s_r.int_n_d,
                            s_r.st != sense_pkg::H_IDLE};
          sense_pkg::APB_IRQ_STAT: s_nxt.prdata = {30'h00000000, s_r.stat};
          sense_pkg::APB_IRQ_MASK: s_nxt.prdata = {30'h00000000, s_r.mask};
          default: s_nxt.prdata = 32'h00000000;
        endcase
      end
    end

    // ------------------------------------------------------------
    // Interrupt events; set wins over the clear
    // ------------------------------------------------------------
    s_nxt.int_n_d = link.int_n;
    ev_int = s_r.int_n_d && !link.int_n;
    if (ev_done) begin
      s_nxt.stat[sense_pkg::IRQ_DONE] = 1'b1;
    end
    if (ev_int) begin
      s_nxt.stat[sense_pkg::IRQ_SENSOR] = 1'b1;
    end
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.st <= sense_pkg::H_IDLE;
      s_r.int_n_d <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.req = s_r.req;
  assign link.we = s_r.we;
  assign link.addr = s_r.addr;
  assign link.wdata = s_r.wdata;
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign irq = s_r.irq;

endmodule : sense_host

// ---- tb/light_prox_sense_sequencer_checker.sv ----
// Link protocol and phase sequencing assertions
module light_prox_sense_sequencer_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link
  input wire logic req,
  input wire logic we,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic int_n,
  // Sensor outputs
  input wire logic led_drive_pin,
  input wire logic [1:0] phase
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // --------
  // Sequences
  // --------
  sequence s_taken;
    req && !ack;
  endsequence
  sequence s_idle_end;
    phase == 2'b00 ##1 phase != 2'b00;
  endsequence
  sequence s_als_end;
    phase == 2'b01 ##1 phase != 2'b01;
  endsequence
  sequence s_ir_end;
    phase == 2'b11 ##1 phase != 2'b11;
  endsequence

  // --------
  // Properties
  // --------
  AST_ACK_NEXT: assert property (s_taken |=> ack)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  AST_REQ_HELD: assert property (s_taken |=> req && $stable(addr) && $stable(we)
    && $stable(wdata))
    else $error("request dropped before ack");
  AST_RDATA_HOLD: assert property (!(req && !we && !ack) |=> $stable(rdata))
    else $error("read data moved without a read");
  AST_INT_STICKY: assert property (!int_n && !req |=> !int_n)
    else $error("interrupt released without host access");
  // Idle for a while so no late compare can re-raise the flag
  AST_READ_CLEARS: assert property ((s_taken ##0 (!we && addr == 4'h0 && phase == 2'b00
    && $past(phase, 8) == 2'b00)) |=> ack && int_n)
    else $error("read of command one left interrupt set");
  AST_LED_IN_PROX: assert property (led_drive_pin |-> phase == 2'b10
    || $past(phase) == 2'b10)
    else $error("led on outside proximity phase");
  AST_START_ALS: assert property (s_idle_end |-> phase == 2'b01)
    else $error("cycle did not start with ambient");
  AST_ALS_TO_IR: assert property (s_als_end |-> phase == 2'b11)
    else $error("ambient not followed by infrared");
  AST_IR_TO_PROX: assert property (s_ir_end |-> phase == 2'b10)
    else $error("infrared not followed by proximity");
endmodule : light_prox_sense_sequencer_checker

// ---- tb/test_light_prox_sense_sequencer.sv ----
// Bench: host and sensor ends joined over the link, driven over APB
module test_light_prox_sense_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam longint SCALE_OHM = 49_900;
  localparam int INITW = 20;
  // Truncated clock divider, as a tick must be whole clocks
  localparam int DIV = int'(sense_pkg::CLK_HZ * SCALE_OHM
    / (sense_pkg::OSC_REF_HZ * sense_pkg::SCALE_REF_OHM));
  localparam logic [7:0] CFG [4] = '{8'h0c, 8'hc8, 8'h04, 8'h8c};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, irq, led_drive_pin;
  logic [1:0] led_current_sel, phase;
  logic [15:0] als_level = 16'h0, ir_level = 16'h0, prox_level = 16'h0;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0, als_len = 0, als_ends = 0, run_len = 0, tog = 0, last_tog = 0, led_hi = 0;
  logic [1:0] prev_ph = 2'b00;
  logic prev_led = 1'b0;
  logic mod_on = 1'b0;
  logic [12:0] seen[$];

  always #20 clk = ~clk;

  sense_link_if link();
  sense_host #(.INIT_WAIT_CYC(INITW)) i_sense_host (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .irq(irq), .link(link));
  light_prox_sense_sequencer #(.SCALE_OHM(SCALE_OHM)) i_light_prox_sense_sequencer (.clk(clk),
    .rst(rst), .link(link), .als_level(als_level), .ir_level(ir_level),
    .prox_level(prox_level), .led_drive_pin(led_drive_pin),
    .led_current_sel(led_current_sel), .phase(phase));
  light_prox_sense_sequencer_checker i_light_prox_sense_sequencer_checker (.clk(clk),
    .rst(rst), .req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata),
    .ack(link.ack), .rdata(link.rdata), .int_n(link.int_n),
    .led_drive_pin(led_drive_pin), .phase(phase));

  // --------
  // Checks and bus tasks
  // --------
  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val

  task automatic chk_cyc(input string nm, input int e, input int g);
    n_tests++;
    if (g != e) begin
      err_count++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_cyc

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk_val("pready", 32'h1, {31'h0, pready});
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // Host runs one link access and polls until it is no longer busy
  task automatic lnk(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    logic [31:0] s;
    int n;
    n = 0;
    apb(1'b1, sense_pkg::APB_CMD, {8'h00, d, 3'h0, w, a, 8'h01}, s);
    do begin
      apb(1'b0, sense_pkg::APB_STATUS, 32'h0, s);
      n++;
    end while (s[0] !== 1'b0 && n < 20);
    chk_val("busy", 32'h0, {31'h0, s[0]});
    q = s[15:8];
  endtask : lnk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    lnk(1'b1, a, d, q);
  endtask : wr

  task automatic wait_ph(input logic [1:0] p, input int lim);
    int n;
    n = 0;
    while (phase !== p && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk_val("phase", {30'h0, p}, {30'h0, phase});
  endtask : wait_ph

  function automatic logic [15:0] exp_data(input logic s, input logic [15:0] p,
                                           input logic [15:0] i, input int n);
    int m, d, lim;
    m = (1 << n) - 1;
    lim = 1 << (n - 1);
    d = int'(p) & m;
    if (s) d = d - (int'(i) & m);
    if (s && d < -lim) d = -lim;
    if (s && d > lim - 1) d = lim - 1;
    return d[15:0];
  endfunction : exp_data

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // --------
  // Link and phase monitor
  // --------
  always @(posedge clk) begin
    cyc++;
    if (link.ack === 1'b1) seen.push_back({link.addr, link.we, link.wdata});
    if (phase == 2'b10 && prev_ph == 2'b10 && led_drive_pin !== prev_led) begin
      if (mod_on && last_tog > 0)
        chk_cyc("led half", sense_pkg::MOD_HALF_CYC, cyc - last_tog);
      last_tog = cyc;
      tog++;
    end
    if (phase == 2'b10 && led_drive_pin === 1'b1) led_hi++;
    if (phase === prev_ph) begin
      run_len++;
    end else begin
      if (prev_ph == 2'b01) als_len = run_len;
      if (prev_ph == 2'b01) als_ends++;
      run_len = 1;
      last_tog = 0;
    end
    prev_ph = phase;
    prev_led = led_drive_pin;
  end

  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end

  // --------
  // Tests
  // --------
  initial begin
    logic [31:0] q, r;
    logic [7:0] b, lo, c2;
    logic [3:0] tl, th, v;
    int m, t0, n, nb;
    void'($urandom(7));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 10; a++) begin
      lnk(1'b0, 4'(a), 8'h00, b);
      chk_val("reset reg", (a == 6 || a == 7) ? 32'hff : 32'h0, {24'h0, b});
    end
    $display("reset values done");
    wr(4'h0, 8'h04);
    chk_val("int forced", 32'h0, {31'h0, link.int_n});
    apb(1'b1, sense_pkg::APB_IRQ_MASK, 32'h3, q);
    apb(1'b1, sense_pkg::APB_IRQ_STAT, 32'h3, q);
    seen.delete();
    t0 = cyc;
    apb(1'b1, sense_pkg::APB_CMD, 32'h2, q);
    n = 0;
    do begin
      apb(1'b0, sense_pkg::APB_IRQ_STAT, 32'h0, q);
      n++;
    end while (q[0] !== 1'b1 && n < 40);
    chk_cyc("init writes", 2, seen.size());
    chk_val("init test reg", {19'h0, 4'h8, 1'b1, 8'h00}, {19'h0, seen[0]});
    chk_val("init cmd1", {19'h0, 4'h0, 1'b1, 8'h00}, {19'h0, seen[1]});
    chk_val("init wait", 32'h1, {31'h0, cyc - t0 >= INITW});
    chk_val("int cleared", 32'h1, {31'h0, link.int_n});
    chk_val("irq done", 32'h1, {31'h0, irq});
    $display("init done");
    tl = 4'(1 + $urandom % 6);
    th = 4'(tl + 2 + $urandom % (13 - tl));
    wr(4'h4, {4'h0, tl});
    wr(4'h5, 8'h00);
    wr(4'h6, {4'h0, th});
    wr(4'h7, 8'h00);
    for (int p = 0; p < 4; p++) begin
      m = (p == 0) ? 1 : (2 << p);
      r = $urandom;
      als_level <= {r[31:20], tl};
      wr(4'h1, 8'h0c);
      wr(4'h0, 8'(8'h80 | p));
      t0 = als_ends;
      n = 0;
      while (als_ends == t0 && n < 500) begin
        @(posedge clk);
        n++;
      end
      chk_cyc("als end", 1, als_ends - t0);
      v = r[0] ? 4'(r[7:4] % tl) : 4'(th + 1 + r[11:8] % (15 - th));
      als_level <= {r[31:20], v};
      t0 = als_ends;
      n = 0;
      while (link.int_n !== 1'b0 && n < 4000) begin
        @(posedge clk);
        n++;
      end
      @(posedge clk);
      chk_cyc("persistence", m, als_ends - t0);
      apb(1'b0, sense_pkg::APB_STATUS, 32'h0, q);
      chk_val("status int", 32'h1, {31'h0, q[1]});
      apb(1'b0, sense_pkg::APB_IRQ_STAT, 32'h0, q);
      chk_val("irq stat fell", 32'h1, {31'h0, q[1]});
      wr(4'h0, 8'(8'h04 | p));
      wait_ph(2'b00, 1000);
      repeat (10) @(posedge clk);
      chk_val("int held", 32'h0, {31'h0, link.int_n});
      lnk(1'b0, 4'h0, 8'h00, b);
      chk_val("flag read", 32'h1, {31'h0, b[2]});
      chk_val("int after read", 32'h1, {31'h0, link.int_n});
      apb(1'b1, sense_pkg::APB_IRQ_MASK, 32'h0, q);
      chk_val("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, sense_pkg::APB_IRQ_MASK, 32'h3, q);
      chk_val("irq unmasked", 32'h1, {31'h0, irq});
      apb(1'b1, sense_pkg::APB_IRQ_STAT, 32'h3, q);
      chk_val("irq cleared", 32'h0, {31'h0, irq});
    end
    $display("interrupt tests done");
    for (int k = 0; k < 4; k++) begin
      r = $urandom;
      c2 = CFG[k] | {2'b00, r[1:0], 4'h0};
      nb = 16 - 4 * int'(c2[3:2]);
      prox_level <= r[31:16];
      ir_level <= {r[15:2], r[3:2]};
      mod_on = c2[6];
      tog = 0;
      led_hi = 0;
      wr(4'h1, c2);
      wr(4'h0, 8'h80);
      wait_ph(2'b10, 3 * (1 << nb) * DIV + 100);
      lnk(1'b0, 4'h2, 8'h00, lo);
      lnk(1'b0, 4'h3, 8'h00, b);
      chk_val("ir data", {16'h0, exp_data(1'b0, ir_level, 16'h0, nb)}, {16'h0, b, lo});
      wr(4'h0, 8'h00);
      wait_ph(2'b00, (1 << nb) * DIV + 100);
      chk_cyc("phase length", (1 << nb) * DIV, als_len);
      chk_val("led current", {30'h0, c2[5:4]}, {30'h0, led_current_sel});
      chk_val("led dc", 32'h1, {31'h0, mod_on || tog == 0});
      chk_val("led on", 32'h1, {31'h0, led_hi > 0 && (!mod_on || tog > 2)});
      lnk(1'b0, 4'h2, 8'h00, lo);
      lnk(1'b0, 4'h3, 8'h00, b);
      chk_val("data", {16'h0, exp_data(c2[7], prox_level, ir_level, nb)}, {16'h0, b, lo});
      $display("config %0d done", k);
    end
    tally_and_finish();
  end
endmodule : test_light_prox_sense_sequencer
